// ### hw/ecp_pkg.sv
// ecp_pkg: shared constants, register offsets and carrier types of the parallel port
// assumes: a single 50 MHz clock domain and a byte-wide host register port
package ecp_pkg;

  // register offsets from the port base address
  localparam logic [10:0] OFS_DATA    = 11'h000;
  localparam logic [10:0] OFS_STATUS  = 11'h001;
  localparam logic [10:0] OFS_CONTROL = 11'h002;
  localparam logic [10:0] OFS_FIFO    = 11'h400;
  localparam logic [10:0] OFS_CFGB    = 11'h401;
  localparam logic [10:0] OFS_ECR     = 11'h402;

  // mode field encodings
  localparam logic [2:0] MODE_STD    = 3'h0;
  localparam logic [2:0] MODE_BIDIR  = 3'h1;
  localparam logic [2:0] MODE_COMPAT = 3'h2;
  localparam logic [2:0] MODE_EXT    = 3'h3;
  localparam logic [2:0] MODE_ENH    = 3'h4;
  localparam logic [2:0] MODE_TEST   = 3'h6;
  localparam logic [2:0] MODE_CONFIG = 3'h7;

  // reset values and fixed read values
  localparam logic [5:0] CONTROL_RST = 6'h00;
  localparam logic [7:0] DATA_RST    = 8'h00;
  localparam logic [2:0] MODE_RST    = 3'h0;
  localparam logic [2:0] ECR_LOW_RST = 3'h0;
  localparam logic [7:0] CFGA_VALUE  = 8'h10;

  // control register field positions
  localparam int CTL_STROBE = 0;
  localparam int CTL_AUTOFD = 1;
  localparam int CTL_INIT   = 2;
  localparam int CTL_SELIN  = 3;
  localparam int CTL_DIR    = 5;

  // buffer geometry and decompression limit
  localparam int         WORD_W     = 8;
  localparam int         FIFO_DEPTH = 16;
  localparam int         FIFO_AW    = 4;
  localparam int         FIFO_W     = 9;
  localparam logic [6:0] RLE_MAX    = 7'h3f;

  typedef enum logic [2:0] {
    fwd_idle, fwd_load, fwd_strobe, rev_wait, rev_ack, rev_expand
  } link_state_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic        dma_ack;
    logic [10:0] addr;
    logic [7:0]  wdata;
  } bus_req_t;

  typedef struct packed {
    logic [7:0] pd;
    logic       nack;
    logic       busy;
    logic       perror;
    logic       select;
    logic       nfault;
  } pin_in_t;

  typedef struct packed {
    logic [7:0] pd;
    logic       pd_oe;
    logic       nstrobe;
    logic       nautofd;
    logic       ninit;
    logic       nselectin;
  } pin_out_t;

endpackage : ecp_pkg

// ### hw/byte_store.sv
// byte_store: small buffer memory with a registered read port
// assumes: caller never reads and writes the same word in one cycle
`timescale 1ns/10ps
module byte_store #(
  parameter int W     = 9,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  // clock, reset, enable
  input  wire logic          clk_sys_i,
  input  wire logic          rst_n_i,
  input  wire logic          ce_i,
  // write port
  input  wire logic          wr_en_i,
  input  wire logic [AW-1:0] wr_addr_i,
  input  wire logic [W-1:0]  wr_data_i,
  // read port
  input  wire logic          rd_en_i,
  input  wire logic [AW-1:0] rd_addr_i,
  output logic      [W-1:0]  rd_data_o
);
  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge clk_sys_i) begin
    if (ce_i && wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_o <= '0;
    end else if (ce_i && rd_en_i) begin
      rd_data_o <= mem[rd_addr_i];
    end
  end
endmodule : byte_store

// ### hw/fifo_level.sv
// fifo_level: pointers and occupancy of the shared buffer
// assumes: push is ignored when full, pop is ignored when empty
`timescale 1ns/10ps
module fifo_level #(
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  // clock, reset, enable
  input  wire logic          clk_sys_i,
  input  wire logic          rst_n_i,
  input  wire logic          ce_i,
  // requests
  input  wire logic          push_i,
  input  wire logic          pop_i,
  input  wire logic          flush_i,
  // state
  output logic      [AW-1:0] wr_ptr_o,
  output logic      [AW-1:0] rd_ptr_o,
  output logic      [AW:0]   count_o,
  output logic               full_o,
  output logic               empty_o
);
  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0]   cnt;
  } lvl_t;

  lvl_t s;
  lvl_t next_s;
  logic do_push;
  logic do_pop;

  assign full_o   = (s.cnt == (AW+1)'(DEPTH));
  assign empty_o  = (s.cnt == '0);
  assign do_push  = push_i && !full_o;
  assign do_pop   = pop_i && !empty_o;
  assign wr_ptr_o = s.wr;
  assign rd_ptr_o = s.rd;
  assign count_o  = s.cnt;

  always_comb begin
    next_s = s;
    if (flush_i) begin
      next_s = '0;
    end else begin
      if (do_push) next_s.wr = s.wr + 1'b1;
      if (do_pop) next_s.rd = s.rd + 1'b1;
      next_s.cnt = s.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else if (ce_i) begin
      s <= next_s;
    end
  end

  chk_level_bound: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    s.cnt <= (AW+1)'(DEPTH)) else $error("buffer count above depth");

  chk_level_track: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    ce_i && !flush_i && push_i && !pop_i && !full_o |=> count_o == $past(count_o) + 1'b1)
    else $error("push did not raise the count");
endmodule : fifo_level

// ### hw/ecp_port.sv
// ecp_port: multi-mode parallel port with extended capabilities transfer engine
// assumes: pin inputs synchronous to clk_sys_i; register strobes are one-cycle pulses
`timescale 1ns/10ps
//
// Contract
// - one shared sixteen-byte buffer for the buffered modes, unused in standard and bidirectional modes
// - every port word is eight bits
// - reverse run-length count repeats next data byte
// - count expands up to 64:1, forward compression absent
// - forward word and strobe driven on the same edge, busy interlocked
// - host ack requests reverse byte, interlocked with ack
// - forward host ack marks command or data
// - in buffered modes, drive data lines only while forward acknowledged; standard and bidirectional modes ignore the answer
// - half duplex, never both directions at once
// - no negotiation, DMA burst channel both ways
// - compatibility buffer writes strobe automatically
// - status, control, extended control in all modes
// - config B reports IRQ and DMA selections
// - init low turns reverse, select-in stays high
// - three-bit mode field selects port behaviour
module ecp_port (
  // clock, reset, enable
  input  wire logic              clk_sys_i,
  input  wire logic              rst_n_i,
  input  wire logic              ce_i,
  // host register port
  input  wire ecp_pkg::bus_req_t bus_i,
  output logic            [7:0]  rdata_o,
  output logic                   rd_valid_o,
  output logic                   dma_req_o,
  // configuration selections
  input  wire logic       [2:0]  irq_sel_i,
  input  wire logic       [2:0]  dma_sel_i,
  input  wire logic              irq_level_i,
  // peripheral pins
  input  wire ecp_pkg::pin_in_t  pin_i,
  output ecp_pkg::pin_out_t      pin_o
);
  typedef struct packed {
    logic [7:0]           port_data_latch;
    logic [5:0]           device_control;
    logic [2:0]           mode;
    logic                 fault_irq_allow_n;
    logic                 dma_allow;
    logic                 service_request_flag;
    logic                 compress;
    ecp_pkg::link_state_t link;
    logic [6:0]           rle_cnt;
    logic                 rle_armed;
    logic [7:0]           rle_byte;
    logic [7:0]           pd_out;
    logic                 tag;
    logic                 rd_pend;
    logic                 rd_fifo;
    logic [7:0]           rd_hold;
    logic                 rd_valid;
    logic [7:0]           rdata;
  } state_t;

  state_t s;
  state_t next_s;

  logic [ecp_pkg::FIFO_W-1:0]  push_data;
  logic [ecp_pkg::FIFO_W-1:0]  mem_q;
  logic [ecp_pkg::FIFO_AW-1:0] wr_ptr;
  logic [ecp_pkg::FIFO_AW-1:0] rd_ptr;
  logic                        push;
  logic                        pop;
  logic                        flush;
  logic                        full;
  logic                        empty;
  logic [10:0]                 addr;
  logic                        dir_rev;
  logic                        fifo_mode;
  logic                        fwd_ok;
  logic                        rev_ok;
  logic                        in_rev;

  // dma acknowledge always targets the buffer window
  assign addr      = bus_i.dma_ack ? ecp_pkg::OFS_FIFO : bus_i.addr;
  assign dir_rev   = s.device_control[ecp_pkg::CTL_DIR];
  assign fifo_mode = (s.mode == ecp_pkg::MODE_COMPAT) || (s.mode == ecp_pkg::MODE_EXT)
                     || (s.mode == ecp_pkg::MODE_TEST) || (s.mode == ecp_pkg::MODE_CONFIG);
  // engine runs one direction only, chosen by direction bit and peripheral answer
  assign fwd_ok = !dir_rev && pin_i.perror && ((s.mode == ecp_pkg::MODE_COMPAT)
                  || (s.mode == ecp_pkg::MODE_EXT));
  assign rev_ok = dir_rev && !pin_i.perror && (s.mode == ecp_pkg::MODE_EXT);
  assign in_rev = s.link inside {ecp_pkg::rev_wait, ecp_pkg::rev_ack, ecp_pkg::rev_expand};

  byte_store #(
    .W     (ecp_pkg::FIFO_W),
    .DEPTH (ecp_pkg::FIFO_DEPTH),
    .AW    (ecp_pkg::FIFO_AW)
  ) u_store (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .ce_i      (ce_i),
    .wr_en_i   (push && !full),
    .wr_addr_i (wr_ptr),
    .wr_data_i (push_data),
    .rd_en_i   (pop && !empty),
    .rd_addr_i (rd_ptr),
    .rd_data_o (mem_q)
  );

  fifo_level #(
    .DEPTH (ecp_pkg::FIFO_DEPTH),
    .AW    (ecp_pkg::FIFO_AW)
  ) u_level (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .ce_i      (ce_i),
    .push_i    (push),
    .pop_i     (pop),
    .flush_i   (flush),
    .wr_ptr_o  (wr_ptr),
    .rd_ptr_o  (rd_ptr),
    .count_o   (),
    .full_o    (full),
    .empty_o   (empty)
  );

  always_comb begin
    next_s    = s;
    push      = 1'b0;
    pop       = 1'b0;
    flush     = 1'b0;
    push_data = '0;
    next_s.rd_pend  = 1'b0;
    next_s.rd_valid = s.rd_pend;
    if (s.rd_pend) begin
      next_s.rdata = s.rd_fifo ? mem_q[7:0] : s.rd_hold;
    end

    // register writes
    if (bus_i.wr) begin
      case (addr)
        ecp_pkg::OFS_DATA: begin
          if (s.mode == ecp_pkg::MODE_STD || s.mode == ecp_pkg::MODE_BIDIR) begin
            next_s.port_data_latch = bus_i.wdata;
          end else if (s.mode == ecp_pkg::MODE_EXT && !dir_rev) begin
            push      = 1'b1;
            push_data = {1'b1, bus_i.wdata};
          end
        end
        ecp_pkg::OFS_CONTROL: next_s.device_control = bus_i.wdata[5:0];
        ecp_pkg::OFS_FIFO: begin
          if (s.mode == ecp_pkg::MODE_COMPAT || s.mode == ecp_pkg::MODE_TEST
              || (s.mode == ecp_pkg::MODE_EXT && !dir_rev)) begin
            push      = 1'b1;
            push_data = {1'b0, bus_i.wdata};
          end
        end
        ecp_pkg::OFS_CFGB: begin
          if (s.mode == ecp_pkg::MODE_CONFIG) next_s.compress = bus_i.wdata[7];
        end
        ecp_pkg::OFS_ECR: begin
          next_s.mode                 = bus_i.wdata[7:5];
          next_s.fault_irq_allow_n    = bus_i.wdata[4];
          next_s.dma_allow            = bus_i.wdata[3];
          next_s.service_request_flag = bus_i.wdata[2];
          // switching to the standard or bidirectional mode discards stale bytes
          flush = (bus_i.wdata[7:5] == ecp_pkg::MODE_STD)
                  || (bus_i.wdata[7:5] == ecp_pkg::MODE_BIDIR);
        end
        default: ;
      endcase
    end

    // register reads, answered two cycles after the strobe
    if (bus_i.rd) begin
      next_s.rd_pend = 1'b1;
      next_s.rd_fifo = 1'b0;
      next_s.rd_hold = 8'h00;
      case (addr)
        ecp_pkg::OFS_DATA: next_s.rd_hold = pin_i.pd;
        ecp_pkg::OFS_STATUS: next_s.rd_hold = {!pin_i.busy, pin_i.nack, pin_i.perror,
                                               pin_i.select, pin_i.nfault, 3'h0};
        ecp_pkg::OFS_CONTROL: next_s.rd_hold = {2'h0, s.device_control};
        ecp_pkg::OFS_FIFO: begin
          if (s.mode == ecp_pkg::MODE_CONFIG) begin
            next_s.rd_hold = ecp_pkg::CFGA_VALUE;
          end else if (s.mode == ecp_pkg::MODE_TEST
                       || (s.mode == ecp_pkg::MODE_EXT && dir_rev)) begin
            pop            = 1'b1;
            next_s.rd_fifo = 1'b1;
          end
        end
        ecp_pkg::OFS_CFGB: begin
          if (s.mode == ecp_pkg::MODE_CONFIG) begin
            next_s.rd_hold = {s.compress, irq_level_i, irq_sel_i, dma_sel_i};
          end
        end
        ecp_pkg::OFS_ECR: next_s.rd_hold = {s.mode, s.fault_irq_allow_n, s.dma_allow,
                                            s.service_request_flag, full, empty};
        default: ;
      endcase
    end

    // transfer engine
    case (s.link)
      ecp_pkg::fwd_idle: begin
        if (fwd_ok && !empty && !pin_i.busy) begin
          pop         = 1'b1;
          next_s.link = ecp_pkg::fwd_load;
        end else if (rev_ok) begin
          next_s.link = ecp_pkg::rev_wait;
        end
      end
      ecp_pkg::fwd_load: begin
        next_s.pd_out = mem_q[7:0];
        next_s.tag    = mem_q[8];
        next_s.link   = ecp_pkg::fwd_strobe;
      end
      ecp_pkg::fwd_strobe: begin
        if (pin_i.busy) next_s.link = ecp_pkg::fwd_idle;
      end
      ecp_pkg::rev_wait: begin
        if (!rev_ok) begin
          next_s.link = ecp_pkg::fwd_idle;
        end else if (!full && !pin_i.nack) begin
          next_s.link = ecp_pkg::rev_ack;
          if (!pin_i.busy && !pin_i.pd[7]) begin
            // run-length count, clamped to the 64:1 limit
            next_s.rle_cnt   = (pin_i.pd[6:0] > ecp_pkg::RLE_MAX) ? ecp_pkg::RLE_MAX
                               : pin_i.pd[6:0];
            next_s.rle_armed = 1'b1;
          end else if (pin_i.busy && s.rle_armed) begin
            next_s.rle_byte  = pin_i.pd;
            next_s.rle_armed = 1'b0;
            push             = 1'b1;
            push_data        = {1'b0, pin_i.pd};
          end else begin
            push      = 1'b1;
            push_data = {!pin_i.busy, pin_i.pd};
          end
        end
      end
      ecp_pkg::rev_ack: begin
        if (pin_i.nack) begin
          // first copy already stored, a count of zero means no extra copies
          next_s.link = (s.rle_cnt != 7'h00 && !s.rle_armed) ? ecp_pkg::rev_expand
                        : ecp_pkg::rev_wait;
        end
      end
      ecp_pkg::rev_expand: begin
        if (!full) begin
          push           = 1'b1;
          push_data      = {1'b0, s.rle_byte};
          next_s.rle_cnt = s.rle_cnt - 7'h01;
          if (s.rle_cnt == 7'h01) next_s.link = ecp_pkg::rev_wait;
        end
      end
      default: next_s.link = ecp_pkg::fwd_idle;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s                      <= '0;
      s.port_data_latch      <= ecp_pkg::DATA_RST;
      s.device_control       <= ecp_pkg::CONTROL_RST;
      s.mode                 <= ecp_pkg::MODE_RST;
      s.service_request_flag <= ecp_pkg::ECR_LOW_RST[0];
      s.link                 <= ecp_pkg::fwd_idle;
    end else if (ce_i) begin
      s <= next_s;
    end
  end

  // pins and answers
  assign rdata_o    = s.rdata;
  assign rd_valid_o = s.rd_valid;
  assign dma_req_o  = s.dma_allow && ((fwd_ok && !full) || (rev_ok && !empty));

  always_comb begin
    pin_o.pd = (s.mode == ecp_pkg::MODE_STD || s.mode == ecp_pkg::MODE_BIDIR)
               ? s.port_data_latch : s.pd_out;
    case (s.mode)
      ecp_pkg::MODE_STD:   pin_o.pd_oe = 1'b1;
      ecp_pkg::MODE_BIDIR: pin_o.pd_oe = !dir_rev;
      default:             pin_o.pd_oe = fifo_mode && !dir_rev && pin_i.perror
                                         && !in_rev;
    endcase
    pin_o.nstrobe   = (s.link == ecp_pkg::fwd_strobe) ? 1'b0
                      : !s.device_control[ecp_pkg::CTL_STROBE];
    pin_o.ninit     = s.device_control[ecp_pkg::CTL_INIT];
    pin_o.nselectin = (s.mode == ecp_pkg::MODE_EXT) ? 1'b1
                      : !s.device_control[ecp_pkg::CTL_SELIN];
    if (s.mode != ecp_pkg::MODE_EXT) begin
      pin_o.nautofd = !s.device_control[ecp_pkg::CTL_AUTOFD];
    end else if (s.link == ecp_pkg::rev_wait) begin
      pin_o.nautofd = full;
    end else if (s.link == ecp_pkg::rev_ack || s.link == ecp_pkg::rev_expand) begin
      pin_o.nautofd = 1'b1;
    end else begin
      pin_o.nautofd = !s.tag;
    end
  end

  chk_pd_drive: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    pin_o.pd_oe && fifo_mode |-> pin_i.perror && !dir_rev)
    else $error("data lines driven while not forward");

  chk_half_duplex: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    s.link inside {ecp_pkg::rev_wait, ecp_pkg::rev_ack, ecp_pkg::rev_expand}
    |-> !pin_o.pd_oe && s.link != ecp_pkg::fwd_strobe)
    else $error("forward activity during reverse");

  chk_strobe_release: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    ce_i && s.link == ecp_pkg::fwd_strobe && pin_i.busy |=> s.link == ecp_pkg::fwd_idle)
    else $error("strobe not released after busy");

  chk_strobe_data: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    s.link == ecp_pkg::fwd_strobe && $past(s.link) == ecp_pkg::fwd_strobe |-> $stable(pin_o.pd))
    else $error("data moved under strobe");

  chk_rev_request: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    s.mode == ecp_pkg::MODE_EXT && s.link == ecp_pkg::rev_wait && !full |-> !pin_o.nautofd)
    else $error("reverse request missing");

  chk_rle_expand: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    s.link == ecp_pkg::rev_expand && !full |-> push && push_data[7:0] == s.rle_byte)
    else $error("run-length byte not repeated");

  chk_hostack_tag: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    s.mode == ecp_pkg::MODE_EXT && s.link == ecp_pkg::fwd_strobe |-> pin_o.nautofd == !s.tag)
    else $error("forward tag not on host ack");

  chk_read_answer: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i || !ce_i)
    bus_i.rd ##1 ce_i |=> rd_valid_o)
    else $error("read not answered in two cycles");
endmodule : ecp_port

// ### test/ecp_periph_model.sv
// ecp_periph_model: behavioural printer-class peripheral on the far side of the port
// assumes: testbench fills rev_q with {busy level, byte} words and reads fwd_q
`timescale 1ns/10ps
module ecp_periph_model (
  // clock, reset
  input  wire logic               clk_sys_i,
  input  wire logic               rst_n_i,
  // response delay in cycles
  input  wire logic [3:0]         stall_i,
  // pins
  input  wire ecp_pkg::pin_out_t  host_i,
  output ecp_pkg::pin_in_t        pins_o
);
  logic [8:0] rev_q[$];
  logic [8:0] fwd_q[$];
  logic       busy;
  logic       nack;
  logic       drive;
  logic [7:0] word;
  logic [7:0] last_pd;
  logic [3:0] wait_cnt;

  always_comb begin
    // released lines show a changing pattern, not the old value
    pins_o.pd     = host_i.pd_oe ? host_i.pd : (drive ? word : ~last_pd);
    pins_o.nack   = nack;
    pins_o.busy   = busy;
    pins_o.perror = host_i.ninit;
    pins_o.select = 1'b1;
    pins_o.nfault = 1'b1;
  end

  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy     <= 1'b0;
      nack     <= 1'b1;
      drive    <= 1'b0;
      word     <= 8'h00;
      last_pd  <= 8'h00;
      wait_cnt <= 4'h0;
    end else begin
      last_pd <= pins_o.pd;
      if (host_i.ninit) begin
        drive <= 1'b0;
        nack  <= 1'b1;
        if (!busy && !host_i.nstrobe) begin
          if (wait_cnt >= stall_i) begin
            busy     <= 1'b1;
            wait_cnt <= 4'h0;
            fwd_q.push_back({host_i.nautofd, pins_o.pd});
          end else begin
            wait_cnt <= wait_cnt + 4'h1;
          end
        end else if (busy && host_i.nstrobe) begin
          busy <= 1'b0;
        end
      end else if (nack && !host_i.nautofd && host_i.nselectin && rev_q.size() > 0) begin
        if (wait_cnt >= stall_i) begin
          {busy, word} <= rev_q.pop_front();
          drive        <= 1'b1;
          nack         <= 1'b0;
          wait_cnt     <= 4'h0;
        end else begin
          wait_cnt <= wait_cnt + 4'h1;
        end
      end else if (!nack && host_i.nautofd) begin
        nack  <= 1'b1;
        drive <= 1'b0;
      end
    end
  end
endmodule : ecp_periph_model

// ### test/testbench.sv
// testbench: register, buffer and link scenarios for the parallel port
// assumes: peripheral model on the pins, one 50 MHz clock
`timescale 1ns/10ps
module testbench;
  logic              clk_sys_i  = 1'b0;
  logic              rst_n_i    = 1'b0;
  logic [3:0]        stall      = 4'h0;
  int                failures   = 0;
  int                num_checks = 0;
  ecp_pkg::bus_req_t bus        = '0;
  ecp_pkg::pin_in_t  pins;
  ecp_pkg::pin_out_t pout;
  logic [7:0]        rdata;
  logic              rd_valid;
  logic              dma_req;

  always #10 clk_sys_i = ~clk_sys_i;

  ecp_port i_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .bus_i(bus),
    .rdata_o(rdata), .rd_valid_o(rd_valid), .dma_req_o(dma_req), .irq_sel_i(3'h5),
    .dma_sel_i(3'h3), .irq_level_i(1'b1), .pin_i(pins), .pin_o(pout));
  ecp_periph_model i_per (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .stall_i(stall),
    .host_i(pout), .pins_o(pins));

  task automatic print_verdict();
    if (failures == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    bus.wr <= 1'b1;
    bus.addr <= a;
    bus.wdata <= d;
    @(posedge clk_sys_i);
    bus.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [10:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    bus.rd <= 1'b1;
    bus.addr <= a;
    @(posedge clk_sys_i);
    bus.rd <= 1'b0;
    d = 8'hxx;
    repeat (4) begin
      @(negedge clk_sys_i);
      if (rd_valid === 1'b1) d = rdata;
    end
  endtask : rd

  task automatic rdc(input logic [10:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    check({1'b0, d}, {1'b0, exp});
  endtask : rdc

  // poll until the buffer holds a word, then pop and compare it
  task automatic pop_exp(input logic [7:0] exp);
    logic [7:0] d;
    d = 8'h01;
    repeat (50) if (d[0] === 1'b1) rd(ecp_pkg::OFS_ECR, d);
    rdc(ecp_pkg::OFS_FIFO, exp);
  endtask : pop_exp

  task automatic wait_fwd(input int n);
    repeat (400) if (i_per.fwd_q.size() < n) @(posedge clk_sys_i);
  endtask : wait_fwd

  task automatic t_reset();
    rdc(ecp_pkg::OFS_ECR, {ecp_pkg::MODE_RST, ecp_pkg::ECR_LOW_RST, 2'b01});
    rdc(ecp_pkg::OFS_CONTROL, {2'b00, ecp_pkg::CONTROL_RST});
    rdc(ecp_pkg::OFS_STATUS, 8'hd8);
    check({5'h00, pout.nstrobe, pout.nautofd, pout.ninit, pout.nselectin}, 9'h00d);
  endtask : t_reset

  task automatic t_config();
    wr(ecp_pkg::OFS_ECR, {ecp_pkg::MODE_CONFIG, 5'h00});
    rdc(ecp_pkg::OFS_FIFO, ecp_pkg::CFGA_VALUE);
    rdc(ecp_pkg::OFS_CFGB, {1'b0, 1'b1, 3'h5, 3'h3});
    wr(ecp_pkg::OFS_CONTROL, 8'hff);
    rdc(ecp_pkg::OFS_CONTROL, 8'h3f);
    wr(ecp_pkg::OFS_CONTROL, 8'h04);
    rdc(ecp_pkg::OFS_STATUS, 8'hf8);
    rdc(11'h003, 8'h00);
    rdc(ecp_pkg::OFS_ECR, {ecp_pkg::MODE_CONFIG, 5'h01});
  endtask : t_config

  task automatic t_fifo();
    wr(ecp_pkg::OFS_ECR, {ecp_pkg::MODE_TEST, 5'h00});
    for (int i = 0; i < 17; i++) wr(ecp_pkg::OFS_FIFO, 8'h30 + i[7:0]);
    rdc(ecp_pkg::OFS_ECR, {ecp_pkg::MODE_TEST, 5'h02});
    for (int i = 0; i < 16; i++) rdc(ecp_pkg::OFS_FIFO, 8'h30 + i[7:0]);
    rdc(ecp_pkg::OFS_ECR, {ecp_pkg::MODE_TEST, 5'h01});
  endtask : t_fifo

  task automatic t_latch();
    wr(ecp_pkg::OFS_ECR, {ecp_pkg::MODE_STD, 5'h00});
    wr(ecp_pkg::OFS_DATA, 8'ha5);
    rdc(ecp_pkg::OFS_DATA, 8'ha5);
    check({8'h00, pout.pd_oe}, 9'h001);
  endtask : t_latch

  task automatic t_compat();
    i_per.fwd_q.delete();
    stall <= 4'h3;
    wr(ecp_pkg::OFS_ECR, {ecp_pkg::MODE_COMPAT, 5'h00});
    for (int k = 0; k < 3; k++) wr(ecp_pkg::OFS_FIFO, 8'h11 * (k[7:0] + 8'h01));
    wait_fwd(3);
    for (int k = 0; k < 3; k++) check({1'b0, i_per.fwd_q[k][7:0]}, 9'h011 * (k + 1));
    rdc(ecp_pkg::OFS_ECR, {ecp_pkg::MODE_COMPAT, 5'h01});
  endtask : t_compat

  task automatic t_ecp_fwd();
    i_per.fwd_q.delete();
    stall <= 4'h0;
    wr(ecp_pkg::OFS_ECR, {ecp_pkg::MODE_EXT, 5'h08});
    @(negedge clk_sys_i);
    check({8'h00, dma_req}, 9'h001);
    wr(ecp_pkg::OFS_DATA, 8'h85);
    wr(ecp_pkg::OFS_FIFO, 8'h5a);
    wait_fwd(2);
    check(i_per.fwd_q[0], 9'h085);
    check(i_per.fwd_q[1], 9'h15a);
  endtask : t_ecp_fwd

  // count 3 gives four copies; count 0 one copy; count 0x7f is held to 64 copies
  task automatic t_reverse();
    stall <= 4'h2;
    wr(ecp_pkg::OFS_CONTROL, 8'h20);
    @(negedge clk_sys_i);
    check({8'h00, pout.pd_oe}, 9'h000);
    i_per.rev_q = '{9'h003, 9'h177, 9'h000, 9'h155, 9'h07f, 9'h19c, 9'h1e1};
    repeat (4) pop_exp(8'h77);
    pop_exp(8'h55);
    repeat (64) pop_exp(8'h9c);
    pop_exp(8'he1);
    rdc(ecp_pkg::OFS_ECR, {ecp_pkg::MODE_EXT, 5'h09});
    check({8'h00, dma_req}, 9'h000);
  endtask : t_reverse

  initial begin
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_config();
    t_fifo();
    t_latch();
    t_compat();
    t_ecp_fwd();
    t_reverse();
    print_verdict();
  end

  initial begin
    repeat (30000) @(posedge clk_sys_i);
    failures++;
    print_verdict();
  end
endmodule : testbench
